// ==== design/ppwi_top.sv ====
// counter array with three pwm channels, watchdog on module 2, ahb-lite registers
//
// Implementation choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ppwi_top
    import ppwi_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic cpu_idle,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    output logic [ppwi_pkg::NUM_CH-1:0] module_output_pin,
    output logic irq_req,
    output logic wd_reset_req
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    ppwi_bus_e bus_state;
    ppwi_bus_e next_bus_state;
    logic [ADDR_W-1:0] addr_q;
    logic [CNT_W-1:0] cnt;
    logic main_overflow_flag;
    logic intermediate_overflow_flag;
    logic [NUM_CH-1:0] channel_event_flag;
    logic counter_run;
    logic idle_stop_control;
    logic watchdog_enable;
    logic [CPS_W-1:0] clock_source_select;
    logic overflow_irq_enable;
    logic reload_select;
    logic intermediate_irq_enable;
    logic [ISEL_W-1:0] inter_bit_select;
    logic global_irq_enable;
    logic array_irq_enable;
    logic [BYTE_W-1:0] ch_mode [NUM_CH];
    logic [BYTE_W-1:0] ch_rd_low [NUM_CH];
    logic [BYTE_W-1:0] ch_rd_high [NUM_CH];
    logic [NUM_CH-1:0] ch_pin;
    logic [NUM_CH-1:0] ch_match;
    logic [NUM_CH-1:0] ch_wd_hit;
    logic [NUM_CH-1:0] ch_wr_mode;
    logic [NUM_CH-1:0] ch_wr_low;
    logic [NUM_CH-1:0] ch_wr_high;
    logic [NUM_CH-1:0] ch_irq_enable;
    logic [BYTE_W-1:0] ch_rd_sel [NUM_CH];

    // ------------------------------------------------------------
    // ahb-lite slave: writes take one data cycle, reads add one wait
    // ------------------------------------------------------------
    // the wait state lets a read follow a write and still see its effect
    wire logic addr_phase = hsel & htrans[HTRANS_ACTIVE] & hready;
    wire logic wr_en = (bus_state == BUS_WRITE);
    wire logic [BYTE_W-1:0] wdata = hwdata[BYTE_W-1:0];

    always_comb begin
        next_bus_state = BUS_IDLE;
        unique case (bus_state)
            BUS_READ: begin
                next_bus_state = BUS_RDATA;
            end
            BUS_IDLE, BUS_WRITE, BUS_RDATA: begin
                if (addr_phase && hwrite) begin
                    next_bus_state = BUS_WRITE;
                end else if (addr_phase) begin
                    next_bus_state = BUS_READ;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            bus_state <= BUS_IDLE;
            addr_q <= OFS_ARRAY_CTRL;
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
        end else if (ce) begin
            bus_state <= next_bus_state;
            hreadyout <= (next_bus_state != BUS_READ);
            hresp <= HRESP_OKAY;
            if (addr_phase) begin
                addr_q <= haddr[ADDR_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    // one select per word, shared by the write strobes and the read mux
    wire logic sel_ctrl = (addr_q == OFS_ARRAY_CTRL);
    wire logic sel_amode = (addr_q == OFS_ARRAY_MODE);
    wire logic sel_cnt_low = (addr_q == OFS_CNT_LOW);
    wire logic sel_cnt_high = (addr_q == OFS_CNT_HIGH);
    wire logic sel_cfg = (addr_q == OFS_PWM_CFG);
    wire logic sel_ien = (addr_q == OFS_IRQ_EN);

    wire logic wr_ctrl = wr_en & sel_ctrl;
    wire logic wr_amode = wr_en & sel_amode;
    wire logic wr_cnt_low = wr_en & sel_cnt_low & ~watchdog_enable;
    wire logic wr_cnt_high = wr_en & sel_cnt_high & ~watchdog_enable;
    wire logic wr_cfg = wr_en & sel_cfg;
    wire logic wr_ien = wr_en & sel_ien;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_dec
            localparam logic [ADDR_W-1:0] CH_OFS = ADDR_W'(OFS_CH_BASE + gi * OFS_CH_STRIDE);
            assign ch_wr_mode[gi] = wr_en & (addr_q == ADDR_W'(CH_OFS + OFS_CH_MODE));
            assign ch_wr_low[gi] = wr_en & (addr_q == ADDR_W'(CH_OFS + OFS_CH_LOW));
            assign ch_wr_high[gi] = wr_en & (addr_q == ADDR_W'(CH_OFS + OFS_CH_HIGH));
            assign ch_irq_enable[gi] = ch_mode[gi][CM_IRQ_EN];
            assign ch_rd_sel[gi] =
                (addr_q == ADDR_W'(CH_OFS + OFS_CH_MODE)) ? ch_mode[gi] :
                (addr_q == ADDR_W'(CH_OFS + OFS_CH_LOW)) ? ch_rd_low[gi] :
                (addr_q == ADDR_W'(CH_OFS + OFS_CH_HIGH)) ? ch_rd_high[gi] : RST_BYTE;
        end
    endgenerate

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    wire logic [BYTE_W-1:0] rd_ctrl = {main_overflow_flag, counter_run,
        intermediate_overflow_flag, 2'h0, channel_event_flag};
    wire logic [BYTE_W-1:0] rd_amode = {idle_stop_control, watchdog_enable, 2'h0,
        clock_source_select, overflow_irq_enable};
    wire logic [BYTE_W-1:0] rd_cfg = {reload_select, intermediate_irq_enable, 3'h0,
        inter_bit_select};
    wire logic [BYTE_W-1:0] rd_ien = {6'h00, array_irq_enable, global_irq_enable};
    wire logic [BYTE_W-1:0] rd_chan = ch_rd_sel[0] | ch_rd_sel[1] | ch_rd_sel[2];
    // unmapped offsets read as zero and still answer okay
    wire logic [BYTE_W-1:0] rd_byte =
        sel_ctrl ? rd_ctrl :
        sel_amode ? rd_amode :
        sel_cnt_low ? cnt[BYTE_W-1:0] :
        sel_cnt_high ? cnt[CNT_W-1:BYTE_W] :
        sel_cfg ? rd_cfg :
        sel_ien ? rd_ien : rd_chan;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            hrdata <= WORD_ZERO;
        end else if (ce && bus_state == BUS_READ) begin
            hrdata <= {PAD_ZERO, rd_byte};
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            counter_run <= 1'b0;
        end else if (ce && wr_ctrl) begin
            counter_run <= wdata[CTRL_RUN];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            watchdog_enable <= RST_ARRAY_MODE[MODE_WD_EN];
            overflow_irq_enable <= RST_ARRAY_MODE[MODE_OVF_IE];
        end else if (ce && wr_amode) begin
            watchdog_enable <= wdata[MODE_WD_EN];
            overflow_irq_enable <= wdata[MODE_OVF_IE];
        end
    end

    // frozen while the watchdog runs; an idle stop already set before it was enabled still stalls it
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            idle_stop_control <= RST_ARRAY_MODE[MODE_IDLE_STOP];
            clock_source_select <= RST_ARRAY_MODE[MODE_CPS_LSB +: CPS_W];
        end else if (ce && wr_amode && !watchdog_enable) begin
            idle_stop_control <= wdata[MODE_IDLE_STOP];
            clock_source_select <= wdata[MODE_CPS_LSB +: CPS_W];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            reload_select <= 1'b0;
            intermediate_irq_enable <= 1'b0;
            inter_bit_select <= RST_BYTE[ISEL_W-1:0];
        end else if (ce && wr_cfg) begin
            reload_select <= wdata[CFG_RELOAD_SEL];
            intermediate_irq_enable <= wdata[CFG_INTER_IE];
            inter_bit_select <= wdata[ISEL_W-1:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            global_irq_enable <= 1'b0;
            array_irq_enable <= 1'b0;
        end else if (ce && wr_ien) begin
            global_irq_enable <= wdata[IEN_GLOBAL];
            array_irq_enable <= wdata[IEN_ARRAY];
        end
    end

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    // counts every enabled clock; clock source decoding is not modelled
    wire logic run_eff = counter_run | watchdog_enable;
    // a byte write replaces the step, so no wrap or match is reported for it
    wire logic cnt_wr = wr_cnt_low | wr_cnt_high;
    wire logic inc = run_eff & ~(cpu_idle & idle_stop_control) & ~cnt_wr;
    wire logic [CNT_W-1:0] cnt_next = CNT_W'(cnt + CNT_ONE);
    wire logic wrap = inc & (cnt == CNT_MAX);
    wire logic low_wrap = inc & (cnt[BYTE_W-1:0] == BYTE_MAX);
    wire logic [CNT_W-1:0] inter_mask = CNT_MAX >> (ISEL_TOP - {1'b0, inter_bit_select});
    wire logic inter_hit = inc & (&(cnt | ~inter_mask));

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            cnt <= RST_WORD;
        end else if (ce) begin
            if (wr_cnt_low) begin
                cnt[BYTE_W-1:0] <= wdata;
            end else if (wr_cnt_high) begin
                cnt[CNT_W-1:BYTE_W] <= wdata;
            end else if (inc) begin
                cnt <= cnt_next;
            end
        end
    end

    // ------------------------------------------------------------
    // event flags: write one to clear, a new event wins over the clear
    // ------------------------------------------------------------
    wire logic clr_main = wr_ctrl & wdata[CTRL_MAIN_OVF];
    wire logic clr_inter = wr_ctrl & wdata[CTRL_INTER_OVF];
    wire logic [NUM_CH-1:0] clr_ch = {NUM_CH{wr_ctrl}} & wdata[NUM_CH-1:0];

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            main_overflow_flag <= 1'b0;
            intermediate_overflow_flag <= 1'b0;
        end else if (ce) begin
            main_overflow_flag <= wrap | (main_overflow_flag & ~clr_main);
            intermediate_overflow_flag <= inter_hit |
                (intermediate_overflow_flag & ~clr_inter);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            channel_event_flag <= '0;
        end else if (ce) begin
            channel_event_flag <= ch_match | (channel_event_flag & ~clr_ch);
        end
    end

    // ------------------------------------------------------------
    // interrupt request and watchdog reset
    // ------------------------------------------------------------
    wire logic irq_pend = (main_overflow_flag & overflow_irq_enable) |
        (intermediate_overflow_flag & intermediate_irq_enable) |
        (|(channel_event_flag & ch_irq_enable));
    wire logic irq_gate = global_irq_enable & array_irq_enable;

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            irq_req <= 1'b0;
        end else if (ce) begin
            irq_req <= irq_pend & irq_gate;
        end
    end

    // held until the chip reset clears it
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            wd_reset_req <= 1'b0;
        end else if (ce) begin
            wd_reset_req <= wd_reset_req | (|ch_wd_hit);
        end
    end

    // ------------------------------------------------------------
    // channels
    // ------------------------------------------------------------
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
            ppwi_channel u_ch (
                .core_clk(core_clk),
                .rst_b(rst_b),
                .ce(ce),
                .wd_mode((gi == WD_CH) && watchdog_enable),
                .wr_mode(ch_wr_mode[gi]),
                .wr_low(ch_wr_low[gi]),
                .wr_high(ch_wr_high[gi]),
                .wdata(wdata),
                .reload_select(reload_select),
                .cnt_next(cnt_next),
                .counter_high_byte(cnt[CNT_W-1:BYTE_W]),
                .inc(inc),
                .wrap(wrap),
                .low_wrap(low_wrap),
                .module_mode_reg(ch_mode[gi]),
                .rd_low(ch_rd_low[gi]),
                .rd_high(ch_rd_high[gi]),
                .module_output_pin(ch_pin[gi]),
                .match_evt(ch_match[gi]),
                .wd_hit(ch_wd_hit[gi])
            );
        end
    endgenerate

    // the channel pins are already flip-flops inside each channel
    assign module_output_pin = ch_pin;
endmodule
`default_nettype wire

// ==== design/ppwi_pkg.sv ====
// shared constants for the counter array, pwm channels and watchdog
package ppwi_pkg;
    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int CNT_W = 16;
    localparam int BYTE_W = 8;
    localparam int NUM_CH = 3;
    localparam int WD_CH = 2;
    localparam int ISEL_W = 3;
    localparam int CPS_W = 3;
    localparam int ADDR_W = 8;
    // ------------------------------------------------------------
    // register offsets (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_ARRAY_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_ARRAY_MODE = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CNT_LOW = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CNT_HIGH = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_PWM_CFG = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_CH_BASE = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_CH_STRIDE = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_CH_MODE = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CH_LOW = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CH_HIGH = 8'h08;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_MAIN_OVF = 7;
    localparam int CTRL_RUN = 6;
    localparam int CTRL_INTER_OVF = 5;
    localparam int MODE_IDLE_STOP = 7;
    localparam int MODE_WD_EN = 6;
    localparam int MODE_CPS_LSB = 1;
    localparam int MODE_OVF_IE = 0;
    localparam int CFG_RELOAD_SEL = 7;
    localparam int CFG_INTER_IE = 6;
    localparam int IEN_GLOBAL = 0;
    localparam int IEN_ARRAY = 1;
    localparam int CM_WIDE = 7;
    localparam int CM_CMP_EN = 6;
    localparam int CM_MATCH_FLAG = 3;
    localparam int CM_PWM = 1;
    localparam int CM_IRQ_EN = 0;
    // ------------------------------------------------------------
    // reset values and fixed patterns
    // ------------------------------------------------------------
    localparam logic [BYTE_W-1:0] RST_ARRAY_MODE = 8'h40;
    localparam logic [BYTE_W-1:0] RST_BYTE = 8'h00;
    localparam logic [CNT_W-1:0] RST_WORD = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
    localparam logic [BYTE_W-1:0] BYTE_MAX = 8'hFF;
    localparam logic [ISEL_W:0] ISEL_TOP = 4'h7;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [23:0] PAD_ZERO = 24'h00_0000;
    // ------------------------------------------------------------
    // bus
    // ------------------------------------------------------------
    localparam int HTRANS_ACTIVE = 1;
    localparam logic HRESP_OKAY = 1'h0;
    typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ, BUS_RDATA} ppwi_bus_e;
endpackage

// ==== design/ppwi_channel.sv ====
// one compare channel: 16-bit pwm with auto-reload, watchdog mode for module 2
`timescale 1ns/1ps
`default_nettype none
module ppwi_channel
    import ppwi_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic wd_mode,
    input wire logic wr_mode,
    input wire logic wr_low,
    input wire logic wr_high,
    input wire logic [ppwi_pkg::BYTE_W-1:0] wdata,
    input wire logic reload_select,
    input wire logic [ppwi_pkg::CNT_W-1:0] cnt_next,
    input wire logic [ppwi_pkg::BYTE_W-1:0] counter_high_byte,
    input wire logic inc,
    input wire logic wrap,
    input wire logic low_wrap,
    output logic [ppwi_pkg::BYTE_W-1:0] module_mode_reg,
    output logic [ppwi_pkg::BYTE_W-1:0] rd_low,
    output logic [ppwi_pkg::BYTE_W-1:0] rd_high,
    output logic module_output_pin,
    output logic match_evt,
    output logic wd_hit
);
    logic [CNT_W-1:0] cmp;
    logic [CNT_W-1:0] reload;
    logic reload_pend;
    wire logic cmp_en = module_mode_reg[CM_CMP_EN];
    // watchdog mode forces software timer behaviour, so no pwm there
    wire logic pwm16 = cmp_en & module_mode_reg[CM_PWM] & module_mode_reg[CM_WIDE] & ~wd_mode;
    wire logic match = inc & (cnt_next == cmp);
    wire logic to_reload = reload_select & ~wd_mode;
    wire logic wr_reload = (wr_low | wr_high) & to_reload;
    wire logic take_reload = wrap & pwm16 & reload_pend;
    wire logic [BYTE_W-1:0] wd_load = BYTE_W'(counter_high_byte + cmp[BYTE_W-1:0]);
    wire logic [BYTE_W-1:0] cmp_en_mask = BYTE_W'(1) << CM_CMP_EN;
    wire logic [BYTE_W-1:0] next_mode_cmp = wr_low & ~to_reload & ~wd_mode ?
        module_mode_reg & ~cmp_en_mask :
        wr_high & ~to_reload & ~wd_mode ?
        module_mode_reg | cmp_en_mask : module_mode_reg;
    // match flag fires on any compare match outside watchdog mode while compare and the match flag bit are both enabled
    assign match_evt = match & cmp_en & module_mode_reg[CM_MATCH_FLAG] & ~wd_mode;
    // comparing on the low-byte wrap gives the first 256-clock window
    assign wd_hit = wd_mode & low_wrap & (cnt_next[CNT_W-1:BYTE_W] == cmp[CNT_W-1:BYTE_W]);
    assign rd_low = to_reload ? reload[BYTE_W-1:0] : cmp[BYTE_W-1:0];
    assign rd_high = to_reload ? reload[CNT_W-1:BYTE_W] : cmp[CNT_W-1:BYTE_W];

    // ------------------------------------------------------------
    // mode register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            module_mode_reg <= RST_BYTE;
        end else if (ce) begin
            if (wr_mode && !wd_mode) begin
                module_mode_reg <= wdata;
            end else begin
                module_mode_reg <= next_mode_cmp;
            end
        end
    end

    // ------------------------------------------------------------
    // compare and reload registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            cmp <= RST_WORD;
            reload <= RST_WORD;
            reload_pend <= 1'b0;
        end else if (ce) begin
            if (wr_low && to_reload) begin
                reload[BYTE_W-1:0] <= wdata;
            end
            if (wr_high && to_reload) begin
                reload[CNT_W-1:BYTE_W] <= wdata;
            end
            // a write that lands with the copy stays pending for the next period
            reload_pend <= wr_reload | (reload_pend & ~take_reload);
            if (take_reload) begin
                cmp <= reload;
            end
            if (wr_low && !to_reload) begin
                cmp[BYTE_W-1:0] <= wdata;
            end
            if (wr_high && wd_mode) begin
                cmp[CNT_W-1:BYTE_W] <= wd_load;
            end else if (wr_high && !to_reload) begin
                cmp[CNT_W-1:BYTE_W] <= wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // pwm output
    // ------------------------------------------------------------
    // match beats overflow, so a compare of zero holds the pin high
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            module_output_pin <= 1'b0;
        end else if (ce) begin
            if (!pwm16) begin
                module_output_pin <= 1'b0;
            end else if (match) begin
                module_output_pin <= 1'b1;
            end else if (wrap) begin
                module_output_pin <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ==== bench/ppwi_top_checker.sv ====
// concurrent checks on the ports of the counter array top
`timescale 1ns/1ps
`default_nettype none
module ppwi_top_checker
    import ppwi_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic [ppwi_pkg::NUM_CH-1:0] module_output_pin,
    input wire logic irq_req,
    input wire logic wd_reset_req
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // ------------------------------------------------------------
    // shadow of the enable word, judged from bus traffic only
    // ------------------------------------------------------------
    logic [7:0] wa_q;
    logic wv_q;
    logic [1:0] en_q;
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            wv_q <= 1'b0;
            en_q <= 2'h0;
        end else if (ce && hready) begin
            wv_q <= hsel && htrans[1] && hwrite;
            wa_q <= haddr[7:0];
            if (wv_q && wa_q == OFS_IRQ_EN) en_q <= hwdata[1:0];
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    sequence s_take; hsel && htrans[1] && hready && ce; endsequence
    sequence s_rd_ans; !hreadyout ##1 hreadyout; endsequence
    property p_rd_wait; s_take ##0 !hwrite |=> s_rd_ans; endproperty
    a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
    property p_wr_nowait; s_take ##0 hwrite |=> hreadyout; endproperty
    a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
    property p_rd_pad; hrdata[31:8] == 24'h00_0000 && !hresp; endproperty
    a_rd_pad: assert property (p_rd_pad) else $error("read pad or resp wrong");
    property p_irq_gate; irq_req |-> $past(en_q) == 2'h3; endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without enables");
    property p_wd_sticky; wd_reset_req |=> wd_reset_req; endproperty
    a_wd_sticky: assert property (p_wd_sticky) else $error("reset request dropped");
    property p_rst_quiet; $rose(rst_b) |-> !wd_reset_req && !irq_req && !module_output_pin; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
    property p_freeze; !ce |=> $stable({module_output_pin, irq_req, wd_reset_req}); endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");
    property p_one_wait; $fell(hreadyout) |=> hreadyout; endproperty
    a_one_wait: assert property (p_one_wait) else $error("wait longer than one");
endmodule
bind ppwi_top ppwi_top_checker chk (.*);
`default_nettype wire

// ==== bench/ppwi_top_bench.sv ====
// self-checking bench for the counter array top
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
module ppwi_top_bench;
    import ppwi_pkg::*;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, r, q;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    wire logic hreadyout, irq_req, wd_reset_req;
    wire logic [31:0] hrdata;
    wire logic [2:0] pin;
    int fails = 0, n_checks = 0, cyc = 0, w;
    always #2.5 core_clk = ~core_clk;
    ppwi_top dut (.core_clk(core_clk), .rst_b(rst_b), .ce(ce), .cpu_idle(1'b0), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(),
        .module_output_pin(pin), .irq_req(irq_req), .wd_reset_req(wd_reset_req));
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    // width in cycles of the next high pulse on channel 0
    task automatic pulse();
        w = 0;
        while (pin[0] !== 1'b1) @(posedge core_clk);
        while (pin[0] === 1'b1) begin
            @(posedge core_clk);
            w++;
        end
    endtask
    task automatic s_wd();
        bus(0, 8'h04, 0);
        `CHK(r[7:0], 8'h40)
        bus(1, 8'h04, 32'hCE);
        bus(0, 8'h04, 0);
        `CHK(r[7:0], 8'h40)
        bus(1, 8'h00, 0);
        bus(0, 8'h00, 0);
        `CHK(r[6], 1'b0)
        bus(0, 8'h08, 0);
        q = r;
        bus(1, 8'h08, 32'h55);
        bus(0, 8'h08, 0);
        `CHK(8'(r[7:0] - q[7:0]), 8'h07)
        bus(1, 8'h40, 32'hC2);
        bus(0, 8'h40, 0);
        `CHK(r[7:0], 8'h00)
        bus(1, 8'h44, 32'h01);
        bus(1, 8'h48, 32'h77);
        bus(0, 8'h48, 0);
        `CHK(r[7:0], 8'h01)
        for (w = 0; w < 600 && wd_reset_req !== 1'b1; w++) @(posedge core_clk);
        `CHK(w > 150 && wd_reset_req === 1'b1, 1'b1)
        rst_b <= 1'b0;
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
    endtask
    task automatic s_pwm();
        bus(0, 8'h04, 0);
        `CHK(r[7:0], 8'h40)
        bus(1, 8'h04, 0);
        bus(1, 8'h00, 32'h40);
        bus(1, 8'h20, 32'hC2);
        bus(1, 8'h24, 32'hF0);
        bus(0, 8'h20, 0);
        `CHK(r[6], 1'b0)
        bus(1, 8'h28, 32'hFF);
        bus(0, 8'h20, 0);
        `CHK(r[6], 1'b1)
        bus(1, 8'h08, 32'hE0);
        bus(1, 8'h0C, 32'hFF);
        pulse();
        `CHK(w, 16)
        `CHK(pin[2:1], 2'h0)
        bus(0, 8'h00, 0);
        `CHK(r[7:0], 8'hE0)
        `CHK(irq_req, 1'b0)
        bus(1, 8'h10, 32'h80);
        bus(1, 8'h24, 32'hC0);
        bus(1, 8'h28, 32'hFF);
        bus(0, 8'h24, 0);
        `CHK(r[7:0], 8'hC0)
        bus(1, 8'h10, 0);
        bus(0, 8'h24, 0);
        `CHK(r[7:0], 8'hF0)
        bus(1, 8'h20, 32'hCA);
        for (int i = 0; i < 2; i++) begin
            bus(1, 8'h08, 32'hA0);
            bus(1, 8'h0C, 32'hFF);
            pulse();
            `CHK(w, i ? 64 : 16)
        end
        bus(0, 8'h00, 0);
        `CHK(r[0], 1'b1)
    endtask
    task automatic s_irq();
        bus(1, 8'h04, 32'h01);
        bus(1, 8'h14, 32'h01);
        repeat (2) @(posedge core_clk);
        `CHK(irq_req, 1'b0)
        bus(1, 8'h14, 32'h03);
        repeat (2) @(posedge core_clk);
        `CHK(irq_req, 1'b1)
        ce <= 1'b0;
        repeat (4) @(posedge core_clk);
        ce <= 1'b1;
        bus(1, 8'h00, 32'hC0);
        repeat (2) @(posedge core_clk);
        `CHK(irq_req, 1'b0)
    endtask
    task automatic give_verdict();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ceiling well above the few hundred cycles the scenarios need
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            give_verdict();
        end
    end
    initial begin
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        s_wd();
        s_pwm();
        s_irq();
        give_verdict();
    end
endmodule
`default_nettype wire
